/* File: hdl/lsd_map.svh */
// Purpose: Named offsets, field positions, reset values and timing counts
//          for the line state duration timer.
// Assumes: Included by its bare name from the package and the modules.
// Notes:   Definitions only.
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH

// ***************************************************************
// Control bus geometry
// ***************************************************************
`define LSD_ADDR_W 5
`define LSD_DATA_W 8

// ***************************************************************
// Register offsets
// ***************************************************************
`define LSD_ADDR_NOISE_COUNT 5'h0f
`define LSD_ADDR_NOISE_PRE 5'h10
`define LSD_ADDR_STATE_LIM 5'h11
`define LSD_ADDR_PRE_LIM 5'h12

// ***************************************************************
// Field positions and widths
// ***************************************************************
`define LSD_MAIN_W 7
`define LSD_PRE_W 8
`define LSD_MAIN_MSB 6
`define LSD_MAIN_LSB 0
`define LSD_PRE_MSB 7
`define LSD_PRE_LSB 0
`define LSD_SEEN_BIT 7

// ***************************************************************
// Reset values
// ***************************************************************
`define LSD_STATE_LIM_RST 7'h00
`define LSD_PRE_LIM_RST 8'h00
`define LSD_MAIN_RST 7'h00
`define LSD_PRESC_RST 8'h00
`define LSD_RDATA_RST 8'h00
`define LSD_UNMAPPED_READ 8'h00
`define LSD_RESERVED_BIT 1'b0

// ***************************************************************
// Line state codes
// ***************************************************************
`define LSD_LS_QUIET 3'h0
`define LSD_LS_IDLE 3'h1
`define LSD_LS_MASTER 3'h2
`define LSD_LS_HALT 3'h3
`define LSD_LS_ACTIVE 3'h4
`define LSD_LS_NOISE 3'h5
`define LSD_LS_UNKNOWN 3'h6
`define LSD_LS_NO_SIGNAL 3'h7
`define LSD_LS_RESET 3'h0

// ***************************************************************
// Timing
// ***************************************************************
`define LSD_CLK_PERIOD_NS 10
`define LSD_TICK_NS 80
`define LSD_TICK_CYCLES (`LSD_TICK_NS / `LSD_CLK_PERIOD_NS)
`define LSD_TICK_CNT_W 3
`define LSD_TICK_CNT_RST 3'h0

`endif

/* File: hdl/lsd_pkg.sv */
// Purpose: Types shared by the line state duration timer modules.
// Assumes: lsd_map.svh supplies every number.
// Notes:   Line state classification lives here as functions.
`include "lsd_map.svh"

package lsd_pkg;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [2:0] {
      LSD_LS_QUIET_E = `LSD_LS_QUIET,
      LSD_LS_IDLE_E = `LSD_LS_IDLE,
      LSD_LS_MASTER_E = `LSD_LS_MASTER,
      LSD_LS_HALT_E = `LSD_LS_HALT,
      LSD_LS_ACTIVE_E = `LSD_LS_ACTIVE,
      LSD_LS_NOISE_E = `LSD_LS_NOISE,
      LSD_LS_UNKNOWN_E = `LSD_LS_UNKNOWN,
      LSD_LS_NO_SIGNAL_E = `LSD_LS_NO_SIGNAL
   } lsd_line_state_t;

   typedef struct packed {
      logic req;
      logic write;
      logic [`LSD_ADDR_W-1:0] addr;
      logic [`LSD_DATA_W-1:0] wdata;
   } lsd_cbus_req_t;

   typedef struct packed {
      logic [`LSD_MAIN_W-1:0] main;
      logic [`LSD_PRE_W-1:0] pre;
   } lsd_cnt_t;

   // ***************************************************************
   // Line state classes
   // ***************************************************************
   function automatic logic lsd_is_steady_ls(input lsd_line_state_t ls);
      lsd_is_steady_ls = (ls == LSD_LS_HALT_E) || (ls == LSD_LS_IDLE_E) ||
                         (ls == LSD_LS_MASTER_E) || (ls == LSD_LS_QUIET_E) ||
                         (ls == LSD_LS_NO_SIGNAL_E);
   endfunction

   function automatic logic lsd_is_noisy_ls(input lsd_line_state_t ls);
      lsd_is_noisy_ls = (ls == LSD_LS_NOISE_E) || (ls == LSD_LS_ACTIVE_E) ||
                        (ls == LSD_LS_UNKNOWN_E);
   endfunction

endpackage

/* File: hdl/lsd_cnt_pair.sv */
// Purpose: Down counter chained behind a prescale down counter.
// Assumes: i_tick is a one-cycle pulse every 80 ns; reset already synchronised.
// Notes:   A reload request wins over counting in the same cycle.
module lsd_cnt_pair
   import lsd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_tick,
   input wire logic i_count_en,
   input wire logic i_wrap_ok,
   input wire logic i_reload,
   input wire logic [`LSD_MAIN_W-1:0] i_main_limit,
   input wire logic [`LSD_PRE_W-1:0] i_pre_limit,
   output lsd_cnt_t o_cnt,
   output logic o_expired
);

   // ***************************************************************
   // Next state
   // ***************************************************************
   lsd_cnt_t cnt_d;
   lsd_cnt_t cnt_q;
   logic exp_d;
   logic exp_q;

   always_comb begin
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (i_reload) begin
         cnt_d.main = i_main_limit; // R10 R11
         cnt_d.pre = i_pre_limit; // R10 R11
      end else if (i_tick && i_count_en) begin
         if (cnt_q.pre == '0) begin
            if (cnt_q.main == '0) begin
               // Both at zero: terminal count, restart the whole period
               if (i_wrap_ok) begin
                  cnt_d.main = i_main_limit; // R9
                  cnt_d.pre = i_pre_limit; // R9
                  exp_d = 1'b1; // R7
               end
            end else begin
               cnt_d.main = cnt_q.main - 7'h01; // R6 R15
               cnt_d.pre = i_pre_limit; // R8
            end
         end else begin
            cnt_d.pre = cnt_q.pre - 8'h01; // R8
         end
      end
      // Otherwise both counters hold R16
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q.main <= `LSD_MAIN_RST;
         cnt_q.pre <= `LSD_PRESC_RST;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign o_cnt = cnt_q;
   assign o_expired = exp_q;

endmodule

/* File: hdl/lsd_timer.sv */
// Purpose: Line state duration timer with noise counter snapshots, reached
//          over the control bus interface.
// Assumes: All inputs synchronous to i_clk (100 MHz); one access per i_cb.req.
// Notes:   The interrupt condition register lives elsewhere; this block only
//          pulses o_write_reject toward it.
//
// Summary of operation
// R1: Noise count read returns value at read
// R2: Noise count write rejected, flag raised
// R3: Count in bits 0-6, change seen bit 7
// R4: Prescale snapshot read returns all eight bits
// R5: Prescale snapshot write ignored, flag raised
// R6: State counter steps when prescale zero, steady
// R7: Period is (prescale+1) times (limit+1) ticks
// R8: Prescale counts per tick, reloads at zero
// R9: Both zero while steady reloads both
// R10: Change into steady state restarts both
// R11: Writing either limit loads both counters
// R12: State limit holds seven bit start value
// R13: State limit bit 7 reads zero, ignored
// R14: Prescale limit holds eight bit start value
// R15: Noise counter steps on prescale zero, noise
// R16: Other line states freeze both counters
// R17: Snapshot stays stable through its read
module lsd_timer
   import lsd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input lsd_cbus_req_t i_cb,
   input lsd_line_state_t i_line_state,
   input wire logic i_noise_event,
   input wire logic i_noise_limit_load,
   input wire logic [`LSD_MAIN_W-1:0] i_noise_limit,
   input wire logic [`LSD_PRE_W-1:0] i_noise_prescale_limit,
   output logic o_cb_ack,
   output logic [`LSD_DATA_W-1:0] o_cb_rdata,
   output logic o_write_reject,
   output logic o_state_expired,
   output logic o_noise_expired,
   output lsd_cnt_t o_state_cnt,
   output lsd_cnt_t o_noise_cnt
);

   // ***************************************************************
   // Reset release
   // ***************************************************************
   // Assertion is immediate; release is held back two edges so that every
   // flip-flop leaves reset in the same cycle.
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   logic rst_n;
   assign rst_n = rst_sync_q;

   // ***************************************************************
   // 80 ns tick
   // ***************************************************************
   logic [`LSD_TICK_CNT_W-1:0] tick_cnt_d;
   logic [`LSD_TICK_CNT_W-1:0] tick_cnt_q;
   logic tick;

   always_comb begin
      tick = (tick_cnt_q == `LSD_TICK_CNT_W'(`LSD_TICK_CYCLES - 1));
      if (tick) begin
         tick_cnt_d = `LSD_TICK_CNT_RST;
      end else begin
         tick_cnt_d = tick_cnt_q + 3'h1;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= `LSD_TICK_CNT_RST;
      end else begin
         tick_cnt_q <= tick_cnt_d;
      end
   end

   // ***************************************************************
   // Line state tracking
   // ***************************************************************
   lsd_line_state_t ls_prev_d;
   lsd_line_state_t ls_prev_q;
   logic ls_change;
   logic ls_steady;
   logic ls_noisy;

   always_comb begin
      ls_prev_d = i_line_state;
      ls_change = (i_line_state != ls_prev_q);
      ls_steady = lsd_is_steady_ls(i_line_state);
      ls_noisy = lsd_is_noisy_ls(i_line_state);
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ls_prev_q <= lsd_line_state_t'(`LSD_LS_RESET);
      end else begin
         ls_prev_q <= ls_prev_d;
      end
   end

   // ***************************************************************
   // Control bus address decode
   // ***************************************************************
   // One hit per register; an address outside the map hits nothing and
   // so reads as zero and writes nowhere.
   logic wr_req;
   logic rd_req;
   logic hit_noise_count;
   logic hit_noise_pre;
   logic hit_state_lim;
   logic hit_pre_lim;

   always_comb begin
      wr_req = i_cb.req && i_cb.write;
      rd_req = i_cb.req && !i_cb.write;
      hit_noise_count = 1'b0;
      hit_noise_pre = 1'b0;
      hit_state_lim = 1'b0;
      hit_pre_lim = 1'b0;
      if (i_cb.addr == `LSD_ADDR_NOISE_COUNT) begin
         hit_noise_count = 1'b1;
      end else if (i_cb.addr == `LSD_ADDR_NOISE_PRE) begin
         hit_noise_pre = 1'b1;
      end else if (i_cb.addr == `LSD_ADDR_STATE_LIM) begin
         hit_state_lim = 1'b1;
      end else if (i_cb.addr == `LSD_ADDR_PRE_LIM) begin
         hit_pre_lim = 1'b1;
      end
   end

   // ***************************************************************
   // Limit registers
   // ***************************************************************
   logic [`LSD_MAIN_W-1:0] state_lim_d;
   logic [`LSD_MAIN_W-1:0] state_lim_q;
   logic [`LSD_PRE_W-1:0] pre_lim_d;
   logic [`LSD_PRE_W-1:0] pre_lim_q;
   logic lim_write;

   always_comb begin
      state_lim_d = state_lim_q;
      pre_lim_d = pre_lim_q;
      lim_write = 1'b0;
      if (wr_req && hit_state_lim) begin
         // Reserved top bit is never stored
         state_lim_d = i_cb.wdata[`LSD_MAIN_MSB:`LSD_MAIN_LSB]; // R12 R13
         lim_write = 1'b1; // R11
      end
      if (wr_req && hit_pre_lim) begin
         pre_lim_d = i_cb.wdata[`LSD_PRE_MSB:`LSD_PRE_LSB]; // R14
         lim_write = 1'b1; // R11
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_lim_q <= `LSD_STATE_LIM_RST;
         pre_lim_q <= `LSD_PRE_LIM_RST;
      end else begin
         state_lim_q <= state_lim_d;
         pre_lim_q <= pre_lim_d;
      end
   end

   // ***************************************************************
   // Line state change seen bit
   // ***************************************************************
   logic seen_d;
   logic seen_q;

   always_comb begin
      // A change landing on the clearing read survives into the next read
      seen_d = (seen_q && !(rd_req && hit_noise_count)) || ls_change; // R3
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_q <= 1'b0;
      end else begin
         seen_q <= seen_d;
      end
   end

   // ***************************************************************
   // Control bus response
   // ***************************************************************
   logic ack_d;
   logic ack_q;
   logic [`LSD_DATA_W-1:0] rdata_d;
   logic [`LSD_DATA_W-1:0] rdata_q;
   logic reject_d;
   logic reject_q;
   lsd_cnt_t state_cnt;
   lsd_cnt_t noise_cnt;

   always_comb begin
      ack_d = i_cb.req;
      rdata_d = rdata_q;
      reject_d = 1'b0;
      if (wr_req && hit_noise_count) begin
         reject_d = 1'b1; // R2
      end
      if (wr_req && hit_noise_pre) begin
         reject_d = 1'b1; // R5
      end
      if (rd_req) begin
         // Read data is latched once and held until the next read R17
         if (hit_noise_count) begin
            rdata_d = {seen_q, noise_cnt.main}; // R1 R3
         end else if (hit_noise_pre) begin
            rdata_d = noise_cnt.pre; // R4
         end else if (hit_state_lim) begin
            rdata_d = {`LSD_RESERVED_BIT, state_lim_q}; // R12 R13
         end else if (hit_pre_lim) begin
            rdata_d = pre_lim_q; // R14
         end else begin
            rdata_d = `LSD_UNMAPPED_READ;
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         rdata_q <= `LSD_RDATA_RST;
         reject_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         reject_q <= reject_d;
      end
   end

   // ***************************************************************
   // State duration counters
   // ***************************************************************
   // The limits are fed from the next values so that a write loads the
   // freshly written figure, not the old one.
   logic state_reload;
   logic state_exp;

   always_comb begin
      state_reload = (ls_change && ls_steady) || lim_write; // R10 R11
   end

   lsd_cnt_pair u_state_cnt (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_tick(tick),
      .i_count_en(ls_steady), // R6 R8 R16
      .i_wrap_ok(ls_steady), // R9
      .i_reload(state_reload),
      .i_main_limit(state_lim_d),
      .i_pre_limit(pre_lim_d),
      .o_cnt(state_cnt),
      .o_expired(state_exp)
   );

   // ***************************************************************
   // Noise counters
   // ***************************************************************
   // Steady line states hold the noise counters at their start values.
   logic noise_reload;
   logic noise_exp;

   always_comb begin
      noise_reload = ls_steady || i_noise_limit_load;
   end

   lsd_cnt_pair u_noise_cnt (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_tick(tick),
      .i_count_en(i_noise_event), // R15
      .i_wrap_ok(ls_noisy),
      .i_reload(noise_reload),
      .i_main_limit(i_noise_limit),
      .i_pre_limit(i_noise_prescale_limit),
      .o_cnt(noise_cnt),
      .o_expired(noise_exp)
   );

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign o_cb_ack = ack_q;
   assign o_cb_rdata = rdata_q;
   assign o_write_reject = reject_q;
   assign o_state_expired = state_exp;
   assign o_noise_expired = noise_exp;
   assign o_state_cnt = state_cnt;
   assign o_noise_cnt = noise_cnt;

endmodule

/* File: tb/lsd_timer_props.sv */
// Purpose: Port-level properties of the line state duration timer.
// Assumes: Requests start only after the synchronised reset has let go.
// Notes:   Limit copies follow bus writes so that reloads can be judged.
`include "lsd_map.svh"

module lsd_timer_props
   import lsd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input lsd_cbus_req_t i_cb,
   input lsd_line_state_t i_line_state,
   input wire logic o_cb_ack,
   input wire logic [`LSD_DATA_W-1:0] o_cb_rdata,
   input wire logic o_write_reject,
   input wire logic o_state_expired,
   input lsd_cnt_t o_state_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [`LSD_MAIN_W-1:0] lim_q, lim_d;
   logic [`LSD_PRE_W-1:0] plim_q, plim_d;
   logic wr, rd, wr_lim, wr_ro, steady;

   // ***************************************************************
   // Limit shadow
   // ***************************************************************
   always_comb begin
      wr = i_cb.req && i_cb.write;
      rd = i_cb.req && !i_cb.write;
      wr_lim = wr && (i_cb.addr == `LSD_ADDR_STATE_LIM || i_cb.addr == `LSD_ADDR_PRE_LIM);
      wr_ro = wr && (i_cb.addr == `LSD_ADDR_NOISE_COUNT || i_cb.addr == `LSD_ADDR_NOISE_PRE);
      steady = i_line_state inside {LSD_LS_HALT_E, LSD_LS_IDLE_E, LSD_LS_MASTER_E,
                                    LSD_LS_QUIET_E, LSD_LS_NO_SIGNAL_E};
      lim_d = lim_q;
      plim_d = plim_q;
      if (wr && i_cb.addr == `LSD_ADDR_STATE_LIM) lim_d = i_cb.wdata[6:0];
      if (wr && i_cb.addr == `LSD_ADDR_PRE_LIM) plim_d = i_cb.wdata;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lim_q <= '0;
         plim_q <= '0;
      end else begin
         lim_q <= lim_d;
         plim_q <= plim_d;
      end
   end

   // ***************************************************************
   // Properties
   // ***************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   a_ack_follows_req: assert property (i_cb.req |=> o_cb_ack)
      else $error("no ack after request");
   a_ack_only_req: assert property (!i_cb.req |=> !o_cb_ack)
      else $error("ack without request");
   a_reject_ro_write: assert property (wr_ro |=> o_write_reject)
      else $error("snapshot write not rejected");
   a_reject_cause: assert property (o_write_reject |-> $past(wr_ro))
      else $error("reject without snapshot write");
   a_rdata_hold: assert property (!rd |=> $stable(o_cb_rdata))
      else $error("read data moved without a read");
   a_limit_read: assert property (rd && i_cb.addr == `LSD_ADDR_STATE_LIM
      |=> o_cb_rdata == {1'b0, lim_q})
      else $error("state limit read wrong");
   a_prescale_read: assert property (rd && i_cb.addr == `LSD_ADDR_PRE_LIM
      |=> o_cb_rdata == plim_q)
      else $error("prescale limit read wrong");
   a_write_loads: assert property (wr_lim |=> o_state_cnt == {lim_q, plim_q})
      else $error("limit write did not load both");
   a_steady_restart: assert property (steady && i_line_state != $past(i_line_state)
      |=> o_state_cnt == {lim_q, plim_q})
      else $error("no restart on steady state change");
   a_other_freeze: assert property (!steady && !wr_lim |=> $stable(o_state_cnt))
      else $error("counters moved in other line state");
   a_expire_reload: assert property (o_state_expired |-> o_state_cnt == {lim_q, plim_q})
      else $error("expiry without reload");
   a_expire_gap: assert property (o_state_expired |=> !o_state_expired [*7])
      else $error("expiries closer than one tick");
endmodule

bind lsd_timer lsd_timer_props u_props (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cb(i_cb),
   .i_line_state(i_line_state), .o_cb_ack(o_cb_ack), .o_cb_rdata(o_cb_rdata),
   .o_write_reject(o_write_reject), .o_state_expired(o_state_expired),
   .o_state_cnt(o_state_cnt));

/* File: tb/lsd_host_model.sv */
// Purpose: Control bus host that issues single accesses to the timer.
// Assumes: One cycle of req is one access; ack comes one cycle later.
// Notes:   Released fields are inverted so nothing leans on stale lines.
`include "lsd_map.svh"

module lsd_host_model
   import lsd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_ack,
   input wire logic [`LSD_DATA_W-1:0] i_rdata,
   input wire logic i_reject,
   output lsd_cbus_req_t o_cb
);
   timeunit 1ns;
   timeprecision 1ps;

   initial o_cb = '0;

   task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic rej, output logic ok);
      int n;
      ok = 1'b0;
      @(posedge i_clk);
      #1;
      o_cb = '{req: 1'b1, write: wr, addr: a, wdata: d};
      @(posedge i_clk);
      #1;
      // Holding req longer would count as a second access
      o_cb = '{req: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
      for (n = 0; n < 4 && !ok; n++) begin
         @(posedge i_clk);
         if (i_ack === 1'b1) begin
            ok = 1'b1;
            q = i_rdata;
            rej = i_reject;
         end
      end
   endtask
endmodule

/* File: tb/line_state_duration_timer_tb.sv */
// Purpose: Self-checking bench for the line state duration timer.
// Assumes: Limits are kept small so each expiry period stays short.
// Notes:   Noise snapshots are judged only in steady states, where they sit at limits.
`include "lsd_map.svh"
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %0t %s", $time, m); end end

module line_state_duration_timer_tb
   import lsd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic i_clk, i_reset_n, i_noise_event, i_noise_limit_load;
   lsd_cbus_req_t i_cb;
   lsd_line_state_t i_line_state;
   logic [6:0] i_noise_limit;
   logic [7:0] i_noise_prescale_limit, o_cb_rdata, q, d;
   logic o_cb_ack, o_write_reject, o_state_expired, o_noise_expired, rej, ok;
   lsd_cnt_t o_state_cnt, o_noise_cnt, snap;
   int err_count, check_count, seed, seen, n, c;
   logic [6:0] s_lim;
   logic [7:0] p_lim;
   lsd_line_state_t ls_seq[8] = '{LSD_LS_ACTIVE_E, LSD_LS_QUIET_E, LSD_LS_NOISE_E,
      LSD_LS_IDLE_E, LSD_LS_UNKNOWN_E, LSD_LS_MASTER_E, LSD_LS_NO_SIGNAL_E, LSD_LS_HALT_E};

   lsd_timer dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cb(i_cb),
      .i_line_state(i_line_state), .i_noise_event(i_noise_event),
      .i_noise_limit_load(i_noise_limit_load), .i_noise_limit(i_noise_limit),
      .i_noise_prescale_limit(i_noise_prescale_limit), .o_cb_ack(o_cb_ack),
      .o_cb_rdata(o_cb_rdata), .o_write_reject(o_write_reject),
      .o_state_expired(o_state_expired), .o_noise_expired(o_noise_expired),
      .o_state_cnt(o_state_cnt), .o_noise_cnt(o_noise_cnt));

   lsd_host_model host (.i_clk(i_clk), .i_ack(o_cb_ack), .i_rdata(o_cb_rdata),
      .i_reject(o_write_reject), .o_cb(i_cb));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // ***************************************************************
   // Model and helpers
   // ***************************************************************
   function automatic logic [7:0] model_read(input logic [4:0] a);
      case (a)
         `LSD_ADDR_NOISE_COUNT: model_read = {seen[0], i_noise_limit};
         `LSD_ADDR_NOISE_PRE: model_read = i_noise_prescale_limit;
         `LSD_ADDR_STATE_LIM: model_read = {1'b0, s_lim};
         `LSD_ADDR_PRE_LIM: model_read = p_lim;
         default: model_read = 8'h00;
      endcase
   endfunction

   task automatic results();
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd);
      host.access(wr, a, wd, q, rej, ok);
      if (!ok) begin
         err_count++;
         $display("CHECK FAILED %0t no ack", $time);
         results();
      end
   endtask

   task automatic rd_chk(input logic [4:0] a);
      bus(1'b0, a, 8'h00);
      `CHK(q, model_read(a), "read data")
   endtask

   task automatic wait_exp(input logic noise, output int cyc);
      cyc = 0;
      do begin
         @(posedge i_clk);
         #1;
         cyc++;
      end while ((noise ? o_noise_expired : o_state_expired) !== 1'b1 && cyc < 1000);
      if (cyc >= 1000) begin
         err_count++;
         $display("CHECK FAILED %0t no expiry", $time);
         results();
      end
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      seed = 32'ha71a1d7c;
      err_count = 0;
      check_count = 0;
      seen = 0;
      s_lim = 7'h00;
      p_lim = 8'h00;
      i_reset_n = 1'b0;
      i_line_state = LSD_LS_QUIET_E;
      i_noise_event = 1'b0;
      i_noise_limit_load = 1'b0;
      i_noise_limit = 7'($random(seed));
      i_noise_prescale_limit = 8'($random(seed));
      repeat (2) @(posedge i_clk);
      #1 i_reset_n = 1'b1;
      repeat (3) @(posedge i_clk);
      rd_chk(`LSD_ADDR_STATE_LIM);
      rd_chk(`LSD_ADDR_PRE_LIM);
      rd_chk(5'h05);
      for (n = 0; n < 4; n++) begin
         d = (n == 0) ? 8'h80 : 8'($random(seed)) & 8'h83;
         bus(1'b1, `LSD_ADDR_STATE_LIM, d);
         s_lim = d[6:0];
         p_lim = (n == 0) ? 8'h00 : 8'($random(seed)) & 8'h07;
         bus(1'b1, `LSD_ADDR_PRE_LIM, p_lim);
         `CHK(o_state_cnt, {s_lim, p_lim}, "load")
         rd_chk(`LSD_ADDR_STATE_LIM);
         rd_chk(`LSD_ADDR_PRE_LIM);
         wait_exp(1'b0, c);
         wait_exp(1'b0, c);
         `CHK(c, (p_lim + 1) * (s_lim + 1) * 8, "period")
      end
      foreach (ls_seq[k]) begin
         @(posedge i_clk);
         #1;
         i_line_state = ls_seq[k];
         i_noise_event = 1'($random(seed));
         i_noise_limit_load = (k == 2);
         @(posedge i_clk);
         #1;
         i_noise_limit_load = 1'b0;
         if (ls_seq[k] inside {LSD_LS_ACTIVE_E, LSD_LS_NOISE_E, LSD_LS_UNKNOWN_E}) begin
            snap = o_state_cnt;
            repeat (20) @(posedge i_clk);
            #1;
            `CHK(o_state_cnt, snap, "frozen")
         end else begin
            `CHK(o_state_cnt, {s_lim, p_lim}, "restart")
         end
      end
      seen = 1;
      rd_chk(`LSD_ADDR_NOISE_COUNT);
      seen = 0;
      rd_chk(`LSD_ADDR_NOISE_COUNT);
      rd_chk(`LSD_ADDR_NOISE_PRE);
      bus(1'b1, `LSD_ADDR_NOISE_COUNT, 8'hff);
      `CHK(rej, 1'b1, "count write reject")
      rd_chk(`LSD_ADDR_NOISE_COUNT);
      bus(1'b1, `LSD_ADDR_NOISE_PRE, 8'h5a);
      `CHK(rej, 1'b1, "prescale write reject")
      rd_chk(`LSD_ADDR_NOISE_PRE);
      bus(1'b1, `LSD_ADDR_PRE_LIM, p_lim);
      `CHK(rej, 1'b0, "legal write rejected")
      // Short noise limits so that a full noise period fits the run
      @(posedge i_clk);
      #1;
      i_noise_limit = 7'($random(seed)) & 7'h03;
      i_noise_prescale_limit = 8'($random(seed)) & 8'h03;
      @(posedge i_clk);
      #1;
      `CHK(o_noise_cnt, {i_noise_limit, i_noise_prescale_limit}, "noise held")
      i_line_state = LSD_LS_NOISE_E;
      i_noise_event = 1'b1;
      wait_exp(1'b1, c);
      wait_exp(1'b1, c);
      `CHK(c, (i_noise_prescale_limit + 1) * (i_noise_limit + 1) * 8, "noise period")
      results();
   end
endmodule
